/* File: verilog/ref_select_control.sv */
// reference input configuration, reference choice and monitor/status pin control
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Monitor code 11010 drives the AND of lock flag, selected reference status and clock status.
// - Monitor code 11011 drives the feedback clock frequency status inverted.
// - Monitor code 11100 drives low for the second reference in use and high for the first.
// - Monitor codes 11101 and 11110 drive the lock flag and holdover indication, low when true.
// - Monitor code 11111 drives the inverted lock-detect pin comparator output.
// - In manual register choice, bit 6 set feeds the second reference, clear feeds the first.
// - In manual mode bit 5 set lets the selection pin decide, clear lets bit 6 decide.
// - Bit 0 set selects differential reference mode, clear (default) single-ended.
// - The EEPROM status enable bit, set at reset, puts EEPROM status on the status pin.
// - Monitor code 01100 drives low for the first reference in use and high for the second.
module ref_select_control (
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    input  wire logic                           ce,
    input  wire logic [ref_select_pkg::ADDR_W-1:0] reg_addr,
    input  wire logic                           reg_wr_en,
    input  wire logic [7:0]                     reg_wdata,
    input  wire logic                           reg_rd_en,
    output logic      [7:0]                     reg_rdata_q,
    input  wire logic [4:0]                     mon_sel,
    input  wire ref_select_pkg::status_levels_t levels,
    input  wire logic                           auto_mode,
    input  wire logic                           auto_sel_b,
    input  wire logic                           ref_sel_pin,
    input  wire logic                           eeprom_status,
    input  wire logic                           status_src_level,
    output ref_select_pkg::ref_ctrl_t           ref_ctrl_q,
    output logic                                ref_b_in_use_q,
    output logic                                ref_monitor_pin_q,
    output logic                                status_pin_q
);
    logic [7:0] ref_cfg_q;
    logic [7:0] status_cfg_q;
    logic       ref_b_in_use_d;
    logic       mon_level;
    logic       wr_ref;
    logic       wr_status;

    assign wr_ref    = ce & reg_wr_en & (reg_addr == ref_select_pkg::REF_CFG_ADDR);
    assign wr_status = ce & reg_wr_en & (reg_addr == ref_select_pkg::STATUS_CFG_ADDR);

    // reserved bits are masked on write so they always read back as zero
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_cfg_q <= ref_select_pkg::REF_CFG_RESET;
        end else if (wr_ref) begin
            ref_cfg_q <= reg_wdata & ref_select_pkg::REF_CFG_RW_MASK;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_cfg_q <= ref_select_pkg::STATUS_CFG_RESET;
        end else if (wr_status) begin
            status_cfg_q <= reg_wdata;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_q <= 8'h00;
        end else if (ce && reg_rd_en) begin
            unique case (reg_addr)
                ref_select_pkg::REF_CFG_ADDR:    reg_rdata_q <= ref_cfg_q;
                ref_select_pkg::STATUS_CFG_ADDR: reg_rdata_q <= status_cfg_q;
                default:                         reg_rdata_q <= 8'h00;
            endcase
        end
    end

    // control fields straight from the register
    // one driver for the whole struct: per-field assigns would split one variable
    assign ref_ctrl_q = '{
        deglitch_off: ref_cfg_q[ref_select_pkg::DEGLITCH_OFF_BIT],
        diff_mode:    ref_cfg_q[ref_select_pkg::DIFF_BIT],
        pwr_ref_b:    ref_cfg_q[ref_select_pkg::PWR_B_BIT],
        pwr_ref_a:    ref_cfg_q[ref_select_pkg::PWR_A_BIT]
    };

    // reference choice: differential forces the first, then automatic, then manual by pin or register bit
    always_comb begin
        if (ref_cfg_q[ref_select_pkg::DIFF_BIT]) begin
            // second input has no meaning in differential mode
            ref_b_in_use_d = 1'b0;
        end else if (auto_mode) begin
            ref_b_in_use_d = auto_sel_b;
        end else if (ref_cfg_q[ref_select_pkg::USE_PIN_BIT]) begin
            ref_b_in_use_d = ref_sel_pin;
        end else begin
            ref_b_in_use_d = ref_cfg_q[ref_select_pkg::SEL_B_BIT];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_b_in_use_q <= 1'b0;
        end else if (ce) begin
            ref_b_in_use_q <= ref_b_in_use_d;
        end
    end

    ref_monitor_mux u_mon (
        .mon_sel      (mon_sel),
        .levels       (levels),
        .ref_b_in_use (ref_b_in_use_q),
        .level        (mon_level)
    );

    // registered so the pin never glitches while the select code changes
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ref_monitor_pin_q <= 1'b0;
        end else if (ce) begin
            ref_monitor_pin_q <= mon_level;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            status_pin_q <= 1'b0;
        end else if (ce) begin
            status_pin_q <= status_cfg_q[ref_select_pkg::EEPROM_STAT_BIT] ? eeprom_status
                                                                          : status_src_level;
        end
    end

    sequence s_manual_reg;
        ce && !auto_mode && !ref_cfg_q[ref_select_pkg::DIFF_BIT]
           && !ref_cfg_q[ref_select_pkg::USE_PIN_BIT];
    endsequence

    sequence s_manual_pin;
        ce && !auto_mode && !ref_cfg_q[ref_select_pkg::DIFF_BIT]
           && ref_cfg_q[ref_select_pkg::USE_PIN_BIT];
    endsequence

    sequence s_auto_choice;
        ce && auto_mode && !ref_cfg_q[ref_select_pkg::DIFF_BIT];
    endsequence

    sequence s_diff_mode;
        ce && ref_cfg_q[ref_select_pkg::DIFF_BIT];
    endsequence

    sequence s_ref_read;
        ce && reg_rd_en && reg_addr == ref_select_pkg::REF_CFG_ADDR;
    endsequence

    chk_lock_and_code: assert property (@(posedge clock) disable iff (!rst_n)
        ce && mon_sel == 5'h1A |=> ref_monitor_pin_q == $past(levels.digital_lock_flag
            & levels.sel_ref_ok & levels.clk_freq_ok))
        else $error("monitor pin wrong for lock AND code");
    chk_clk_inverted: assert property (@(posedge clock) disable iff (!rst_n)
        ce && mon_sel == 5'h1B |=> ref_monitor_pin_q != $past(levels.clk_freq_ok))
        else $error("monitor pin not inverted clock status");
    chk_ref_used_low: assert property (@(posedge clock) disable iff (!rst_n)
        ce && mon_sel == 5'h1C |=> ref_monitor_pin_q == !$past(ref_b_in_use_q))
        else $error("monitor pin wrong for inverted reference in use");
    chk_lock_holdover: assert property (@(posedge clock) disable iff (!rst_n)
        ce && (mon_sel == 5'h1D || mon_sel == 5'h1E) |=> ref_monitor_pin_q ==
            !$past(mon_sel[0] ? levels.digital_lock_flag : levels.holdover_active))
        else $error("monitor pin wrong for lock or holdover");
    chk_comp_inverted: assert property (@(posedge clock) disable iff (!rst_n)
        ce && mon_sel == 5'h1F |=> ref_monitor_pin_q != $past(levels.lock_pin_comp))
        else $error("monitor pin not inverted comparator");
    chk_reg_choice: assert property (@(posedge clock) disable iff (!rst_n)
        s_manual_reg |=> ref_b_in_use_q == $past(ref_cfg_q[ref_select_pkg::SEL_B_BIT]))
        else $error("register reference choice not followed");
    chk_pin_choice: assert property (@(posedge clock) disable iff (!rst_n)
        s_manual_pin |=> ref_b_in_use_q == $past(ref_sel_pin))
        else $error("selection pin not followed");
    chk_diff_mode: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ref ##1 1'b1 |-> ref_ctrl_q.diff_mode == $past(reg_wdata[0]))
        else $error("differential mode bit not stored");
    chk_eeprom_status: assert property (@(posedge clock) disable iff (!rst_n)
        ce && status_cfg_q[ref_select_pkg::EEPROM_STAT_BIT] |=> status_pin_q == $past(eeprom_status))
        else $error("status pin not showing eeprom status");
    chk_ref_used_high: assert property (@(posedge clock) disable iff (!rst_n)
        ce && mon_sel == 5'h0C |=> ref_monitor_pin_q == $past(ref_b_in_use_q))
        else $error("monitor pin wrong for reference in use");
    chk_power_bits: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ref |=> {ref_ctrl_q.pwr_ref_b, ref_ctrl_q.pwr_ref_a} == $past(reg_wdata[2:1]))
        else $error("power enable bits not stored");
    chk_deglitch_bit: assert property (@(posedge clock) disable iff (!rst_n)
        wr_ref |=> ref_ctrl_q.deglitch_off == $past(reg_wdata[7]))
        else $error("deglitch disable bit not stored");

    // differential mode wins over the automatic choice, so it is left out here
    chk_auto_override: assert property (@(posedge clock) disable iff (!rst_n)
        s_auto_choice |=> ref_b_in_use_q == $past(auto_sel_b))
        else $error("automatic choice not followed");
    chk_diff_forces_a: assert property (@(posedge clock) disable iff (!rst_n)
        s_diff_mode |=> !ref_b_in_use_q)
        else $error("second input in use during differential mode");
    chk_status_source: assert property (@(posedge clock) disable iff (!rst_n)
        ce && !status_cfg_q[ref_select_pkg::EEPROM_STAT_BIT]
            |=> status_pin_q == $past(status_src_level))
        else $error("status pin not showing selected source");
    chk_reset_defaults: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(rst_n) |-> ref_cfg_q == ref_select_pkg::REF_CFG_RESET
            && status_cfg_q == ref_select_pkg::STATUS_CFG_RESET)
        else $error("configuration not at reset values");
    chk_ctrl_stable: assert property (@(posedge clock) disable iff (!rst_n)
        !wr_ref |=> $stable(ref_ctrl_q))
        else $error("control fields changed without a write");
    chk_ref_readback: assert property (@(posedge clock) disable iff (!rst_n)
        s_ref_read |=> reg_rdata_q == $past(ref_cfg_q))
        else $error("reference configuration read back wrong");
    chk_choice_frozen: assert property (@(posedge clock) disable iff (!rst_n)
        !ce |=> $stable(ref_b_in_use_q) && $stable(ref_monitor_pin_q))
        else $error("reference choice moved while clock enable low");
    chk_status_frozen: assert property (@(posedge clock) disable iff (!rst_n)
        !ce |=> $stable(status_pin_q) && $stable(status_cfg_q))
        else $error("status pin moved while clock enable low");
endmodule
`default_nettype wire

/* File: verilog/ref_select_pkg.sv */
// constants and types shared by the reference select and monitor control block
package ref_select_pkg;
    localparam int          ADDR_W            = 10;
    localparam logic [9:0]  REF_CFG_ADDR      = 10'h01C;
    localparam logic [9:0]  STATUS_CFG_ADDR   = 10'h01D;

    // reference_input_config field positions
    localparam int          DEGLITCH_OFF_BIT  = 7;
    localparam int          SEL_B_BIT         = 6;
    localparam int          USE_PIN_BIT       = 5;
    localparam int          PWR_B_BIT         = 2;
    localparam int          PWR_A_BIT         = 1;
    localparam int          DIFF_BIT          = 0;
    // status_pin_eeprom_config field position
    localparam int          EEPROM_STAT_BIT   = 7;

    localparam logic [7:0]  REF_CFG_RESET     = 8'h00;
    localparam logic [7:0]  REF_CFG_RW_MASK   = 8'hE7;
    localparam logic [7:0]  STATUS_CFG_RESET  = 8'h80;

    // monitor select codes handled here (low half; upper half adds 0x10)
    localparam logic [3:0]  MON_SEL_OK        = 4'h5;
    localparam logic [3:0]  MON_UNSEL_OK      = 4'h6;
    localparam logic [3:0]  MON_A_FREQ        = 4'h7;
    localparam logic [3:0]  MON_B_FREQ        = 4'h8;
    localparam logic [3:0]  MON_AB_FREQ       = 4'h9;
    localparam logic [3:0]  MON_LOCK_ALL      = 4'hA;
    localparam logic [3:0]  MON_CLK_FREQ      = 4'hB;
    localparam logic [3:0]  MON_REF_USED      = 4'hC;
    localparam logic [3:0]  MON_LOCK_N        = 4'hD;
    localparam logic [3:0]  MON_HOLDOVER      = 4'hE;
    localparam logic [3:0]  MON_LOCK_CMP      = 4'hF;

    typedef struct packed {
        logic digital_lock_flag;
        logic sel_ref_ok;
        logic unsel_ref_ok;
        logic ref_a_freq_ok;
        logic ref_b_freq_ok;
        logic clk_freq_ok;
        logic holdover_active;
        logic lock_pin_comp;
    } status_levels_t;

    typedef struct packed {
        logic deglitch_off;
        logic diff_mode;
        logic pwr_ref_b;
        logic pwr_ref_a;
    } ref_ctrl_t;
endpackage

/* File: verilog/ref_monitor_mux.sv */
// level selector for the reference monitor pin
`timescale 1ns/1ps
`default_nettype none
module ref_monitor_mux (
    input  wire logic [4:0]                    mon_sel,
    input  wire ref_select_pkg::status_levels_t levels,
    input  wire logic                          ref_b_in_use,
    output logic                               level
);
    logic base;
    logic keep_polarity;

    always_comb begin
        base = 1'b0;
        unique case (mon_sel[3:0])
            ref_select_pkg::MON_SEL_OK:   base = levels.sel_ref_ok;
            ref_select_pkg::MON_UNSEL_OK: base = levels.unsel_ref_ok;
            ref_select_pkg::MON_A_FREQ:   base = levels.ref_a_freq_ok;
            ref_select_pkg::MON_B_FREQ:   base = levels.ref_b_freq_ok;
            ref_select_pkg::MON_AB_FREQ:  base = levels.ref_a_freq_ok & levels.ref_b_freq_ok;
            ref_select_pkg::MON_LOCK_ALL: base = levels.digital_lock_flag & levels.sel_ref_ok
                                                 & levels.clk_freq_ok;
            ref_select_pkg::MON_CLK_FREQ: base = levels.clk_freq_ok;
            ref_select_pkg::MON_REF_USED: base = ref_b_in_use;
            ref_select_pkg::MON_LOCK_N:   base = ~levels.digital_lock_flag;
            ref_select_pkg::MON_HOLDOVER: base = levels.holdover_active;
            ref_select_pkg::MON_LOCK_CMP: base = levels.lock_pin_comp;
            // clock, supply and unlisted codes are driven by other logic; pin rests low
            default:                      base = 1'b0;
        endcase
    end

    // the AND terms and the lock flag read the same in both halves
    assign keep_polarity = (mon_sel[3:0] == ref_select_pkg::MON_AB_FREQ)
                         | (mon_sel[3:0] == ref_select_pkg::MON_LOCK_ALL)
                         | (mon_sel[3:0] == ref_select_pkg::MON_LOCK_N)
                         | (mon_sel[3:0] <  ref_select_pkg::MON_SEL_OK);

    assign level = (mon_sel[4] & ~keep_polarity) ? ~base : base;
endmodule
`default_nettype wire

/* File: tb/ref_source_model.sv */
// far-side model: reference status levels and the external selection pin
`timescale 1ns/1ps
`default_nettype none
module ref_source_model (
    input  wire logic                     clock,
    input  wire logic [8:0]               cmd,
    output logic                          ref_sel_pin,
    output ref_select_pkg::status_levels_t levels
);
    initial begin
        ref_sel_pin = 1'b0;
        levels = '0;
    end
    // sources settle away from the sampling edge, like a real pin driver
    always @(negedge clock) begin
        ref_sel_pin <= cmd[8];
        levels      <= cmd[7:0];
    end
endmodule
`default_nettype wire

/* File: tb/reference_select_monitor_control_test.sv */
// self-checking bench for the reference select and monitor control block
`timescale 1ns/1ps
`default_nettype none
module reference_select_monitor_control_test;
    logic clock = 1'b0, rst_n = 1'b0, ce = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
    logic auto_mode = 1'b0, auto_sel_b = 1'b0, eeprom = 1'b0, src_level = 1'b0;
    logic [9:0] addr = '0;
    logic [7:0] wdata = '0, rdata, d1;
    logic [4:0] mon_sel = '0, codes [8] = '{5'h0C, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h10};
    logic [8:0] cmd = '0;
    logic ref_sel_pin, b_use, mon_pin, stat_pin;
    ref_select_pkg::status_levels_t levels;
    ref_select_pkg::ref_ctrl_t ctrl;
    integer seed = 32'hb89e, mismatches = 0, samples_checked = 0, i;

    always #5 clock = ~clock;

    ref_source_model far (.clock(clock), .cmd(cmd), .ref_sel_pin(ref_sel_pin), .levels(levels));
    ref_select_control dut (.clock(clock), .rst_n(rst_n), .ce(ce), .reg_addr(addr),
        .reg_wr_en(wr_en), .reg_wdata(wdata), .reg_rd_en(rd_en), .reg_rdata_q(rdata),
        .mon_sel(mon_sel), .levels(levels), .auto_mode(auto_mode), .auto_sel_b(auto_sel_b),
        .ref_sel_pin(ref_sel_pin), .eeprom_status(eeprom), .status_src_level(src_level),
        .ref_ctrl_q(ctrl), .ref_b_in_use_q(b_use), .ref_monitor_pin_q(mon_pin),
        .status_pin_q(stat_pin));

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
            mismatches++;
        end
    endtask

    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(negedge clock) {addr, wdata, wr_en} = {a, d, 1'b1};
        @(negedge clock) wr_en = 1'b0;
    endtask

    task automatic rd(input logic [9:0] a, input logic [7:0] exp);
        @(negedge clock) {addr, rd_en} = {a, 1'b1};
        @(negedge clock) rd_en = 1'b0;
        chk(rdata, exp, "read data");
    endtask

    // expected monitor level for a code, the status levels and the reference in use
    function automatic logic mon_exp(input logic [4:0] c, input ref_select_pkg::status_levels_t l,
                                     input logic b);
        case (c)
            5'h0C: return b;
            5'h1A: return l.digital_lock_flag & l.sel_ref_ok & l.clk_freq_ok;
            5'h1B: return ~l.clk_freq_ok;
            5'h1C: return ~b;
            5'h1D: return ~l.digital_lock_flag;
            5'h1E: return ~l.holdover_active;
            5'h1F: return ~l.lock_pin_comp;
            default: return 1'b0;
        endcase
    endfunction

    initial begin
        #200000;
        mismatches++;
        stop_test();
    end

    initial begin
        repeat (12) @(negedge clock);
        rst_n = 1'b1;
        rd(10'h01C, 8'h00);
        rd(10'h01D, 8'h80);
        chk(8'(ctrl), 8'h00, "control after reset");
        wr(10'h01C, 8'hF8);
        rd(10'h01C, 8'hE0);
        chk(8'(ctrl), 8'h08, "deglitch bypass");
        wr(10'h01C, 8'h06);
        chk(8'(ctrl), 8'h03, "receiver power");
        // software powers both receivers down before switching to differential
        wr(10'h01C, 8'h00);
        wr(10'h01C, 8'h01);
        chk(8'(ctrl), 8'h04, "differential mode");
        rd(10'h01E, 8'h00);
        ce = 1'b0;
        wr(10'h01C, 8'h40);
        ce = 1'b1;
        rd(10'h01C, 8'h01);
        // manual choice by register bit or by selection pin, then automatic choice
        for (i = 0; i < 16; i++) begin
            wr(10'h01C, {1'b0, i[1], i[0], 5'h00});
            cmd[8] = i[2];
            {auto_mode, auto_sel_b} = {i[3], !i[1]};
            repeat (3) @(negedge clock);
            chk(8'(b_use), 8'(i[3] ? !i[1] : (i[0] ? i[2] : i[1])), "ref in use");
        end
        auto_mode = 1'b0;
        wr(10'h01C, 8'h20);
        for (i = 0; i < 80; i++) begin
            cmd = 9'($random(seed));
            mon_sel = codes[$random(seed) & 7];
            d1 = 8'($random(seed));
            {eeprom, src_level} = 2'($random(seed));
            wr(10'h01D, d1);
            repeat (3) @(negedge clock);
            chk(8'(b_use), 8'(cmd[8]), "pin choice");
            chk(8'(mon_pin), 8'(mon_exp(mon_sel, levels, cmd[8])), "monitor");
            chk(8'(stat_pin), 8'(d1[7] ? eeprom : src_level), "status pin");
        end
        // differential mode overrides both the pin and the register choice
        cmd[8] = 1'b1;
        wr(10'h01C, 8'h61);
        repeat (3) @(negedge clock);
        chk(8'(b_use), 8'h00, "differential choice");
        stop_test();
    end
endmodule
`default_nettype wire
